/* hw/directional_ground_fault_logic.sv */
// three directional ground fault stages with on-delay and off-delay timing
// assumes measurements are synchronous to i_clk, held between sample ticks
`timescale 1ns/1ps
module directional_ground_fault_logic
    import dirg_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES,
    parameter int OFF_CNT = OFF_DELAY_CYCLES
)(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sample_tick,
    input wire measure_s i_meas,
    input wire logic [ANG_W-1:0] i_max_sensitivity_angle,
    input wire stage_cfg_s i_stage_one_cfg,
    input wire stage_cfg_s i_stage_two_cfg,
    input wire stage_cfg_s i_stage_three_cfg,
    output logic o_ground_direction_stage_one,
    output logic o_ground_direction_stage_two,
    output logic o_ground_direction_stage_three,
    output logic o_angle_in_area
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        stage_s [NUM_STAGES-1:0] stage;
        logic in_area;
        logic [NUM_STAGES-1:0] operate;
    } core_s;

    // operate lags the angle by two edges (area flag first, then operate) and the other measurements by one edge
    core_s state_q;
    core_s state_d;
    stage_cfg_s [NUM_STAGES-1:0] cfg;

    // index the stage settings so one loop serves all three stages
    assign cfg[0] = i_stage_one_cfg;
    assign cfg[1] = i_stage_two_cfg;
    assign cfg[2] = i_stage_three_cfg;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // angle difference folded to its magnitude in the range 0..180 degrees
    function automatic logic in_area_f(input logic [ANG_W-1:0] ang,
                                       input logic [ANG_W-1:0] max_sensitivity_angle);
        logic [ANG_W:0] diff;
        logic [ANG_W-1:0] mag;
        diff = {1'b0, ang} + {1'b0, ANGLE_FULL} - {1'b0, max_sensitivity_angle};
        if (diff >= {1'b0, ANGLE_FULL})
        begin
            diff = diff - {1'b0, ANGLE_FULL};
        end
        if (diff[ANG_W-1:0] > ANGLE_HALF_AREA + ANGLE_HALF_AREA)
        begin
            mag = ANGLE_FULL - diff[ANG_W-1:0];
        end
        else
        begin
            mag = diff[ANG_W-1:0];
        end
        // boundary excluded: a quadrature phasor carries no direction
        in_area_f = (mag < ANGLE_HALF_AREA);
    endfunction

    // a pickup voltage outside its printed range counts as no pickup
    function automatic logic cond_f(input stage_cfg_s c, input measure_s m,
                                    input logic area);
        logic v_ok;
        v_ok = (c.pickup_voltage >= VOLT_MIN) && (c.pickup_voltage <= VOLT_MAX);
        cond_f = (m.current > c.pickup_current)
            && v_ok && (m.voltage > c.pickup_voltage)
            && area
            && !(c.harmonic_restraint_enable && m.harmonic_detect);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        stage_cfg_s c;
        c = '0;
        state_d = state_q;
        state_d.in_area = in_area_f(i_meas.angle, i_max_sensitivity_angle);
        for (int s = 0; s < NUM_STAGES; s++)
        begin
            // stage one never sees restraint since its enable is forced off
            c = cfg[s];
            if (s == 0)
            begin
                c.harmonic_restraint_enable = 1'b0;
            end
            state_d.operate[s] = cond_f(c, i_meas, state_q.in_area);
            if (!c.use_enable)
            begin
                state_d.stage[s].state = ST_IDLE;
                state_d.stage[s].steps = '0;
                state_d.stage[s].cycles = '0;
                state_d.stage[s].trip = 1'b0;
            end
            else
            begin
                case (state_q.stage[s].state)
                    ST_IDLE:
                    begin
                        state_d.stage[s].steps = '0;
                        state_d.stage[s].cycles = '0;
                        // start only on a tick: up to one tick period of start jitter
                        if (state_q.operate[s] && i_sample_tick)
                        begin
                            state_d.stage[s].state = ST_TIMING;
                        end
                    end
                    ST_TIMING:
                    begin
                        if (!state_q.operate[s])
                        begin
                            state_d.stage[s].state = ST_IDLE;
                            state_d.stage[s].steps = '0;
                            state_d.stage[s].cycles = '0;
                        end
                        else if (state_q.stage[s].steps >= c.operate_delay
                                 || state_q.stage[s].steps >= DELAY_MAX)
                        begin
                            // settings above the range clamp to the longest delay
                            state_d.stage[s].state = ST_TRIP;
                            state_d.stage[s].trip = 1'b1;
                        end
                        else if (state_q.stage[s].cycles == CNT_W'(STEP_CNT - 1))
                        begin
                            state_d.stage[s].cycles = '0;
                            state_d.stage[s].steps = state_q.stage[s].steps + 1'b1;
                        end
                        else
                        begin
                            state_d.stage[s].cycles = state_q.stage[s].cycles + 1'b1;
                        end
                    end
                    ST_TRIP:
                    begin
                        state_d.stage[s].cycles = '0;
                        if (!state_q.operate[s])
                        begin
                            state_d.stage[s].state = ST_HOLD;
                        end
                    end
                    ST_HOLD:
                    begin
                        // pickup again in the off-delay returns to trip with no new delay
                        if (state_q.operate[s])
                        begin
                            state_d.stage[s].state = ST_TRIP;
                            state_d.stage[s].cycles = '0;
                        end
                        else if (state_q.stage[s].cycles == CNT_W'(OFF_CNT - 1))
                        begin
                            state_d.stage[s].state = ST_IDLE;
                            state_d.stage[s].trip = 1'b0;
                            state_d.stage[s].steps = '0;
                            state_d.stage[s].cycles = '0;
                        end
                        else
                        begin
                            state_d.stage[s].cycles = state_q.stage[s].cycles + 1'b1;
                        end
                    end
                    default:
                    begin
                        state_d.stage[s].state = ST_IDLE;
                        state_d.stage[s].trip = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // synchronous reset clears every stage to idle with trips low
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_ground_direction_stage_one = state_q.stage[0].trip;
    assign o_ground_direction_stage_two = state_q.stage[1].trip;
    assign o_ground_direction_stage_three = state_q.stage[2].trip;
    assign o_angle_in_area = state_q.in_area;

endmodule

/* hw/dirg_pkg.sv */
// package for the directional ground fault decision logic
// assumes a 25 MHz system clock and a sample tick from the measurement front end
package dirg_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NUM_STAGES = 3;
    localparam int CUR_W = 16;
    localparam int VOLT_W = 10;
    localparam int ANG_W = 9;
    localparam int DLY_W = 10;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------
    // angles and limits
    // ------------------------------------------------------------
    localparam logic [ANG_W-1:0] ANGLE_FULL = 9'h168;
    localparam logic [ANG_W-1:0] ANGLE_HALF_AREA = 9'h05a;
    localparam logic [VOLT_W-1:0] VOLT_MIN = 10'h014;
    localparam logic [VOLT_W-1:0] VOLT_MAX = 10'h3e8;
    localparam logic [DLY_W-1:0] DELAY_MAX = 10'h3e8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int DELAY_STEP_MS = 10;
    localparam int OFF_DELAY_MS = 200;
    localparam int INST_MAX_MS = 50;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
    localparam int OFF_DELAY_CYCLES = CLK_HZ / 1000 * OFF_DELAY_MS;
    localparam int INST_MAX_CYCLES = CLK_HZ / 1000 * INST_MAX_MS;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic use_enable;
        logic harmonic_restraint_enable;
        logic [CUR_W-1:0] pickup_current;
        logic [VOLT_W-1:0] pickup_voltage;
        logic [DLY_W-1:0] operate_delay;
    } stage_cfg_s;

    typedef struct packed {
        logic [CUR_W-1:0] current;
        logic [VOLT_W-1:0] voltage;
        logic [ANG_W-1:0] angle;
        logic harmonic_detect;
    } measure_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TIMING = 2'b01,
        ST_TRIP = 2'b10,
        ST_HOLD = 2'b11
    } stage_state_e;

    typedef struct packed {
        stage_state_e state;
        logic [DLY_W-1:0] steps;
        logic [CNT_W-1:0] cycles;
        logic trip;
    } stage_s;

endpackage

/* tb/dirg_checker_assertions.sv */
// assertions on the ground fault decision block ports
// assumes the bench sets an off-delay of 6 cycles
`timescale 1ns/1ps
module dirg_checker import dirg_pkg::*; #(parameter int STEP_CNT = 4, parameter int OFF_CNT = 6) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sample_tick,
    input wire measure_s i_meas,
    input wire logic [ANG_W-1:0] i_max_sensitivity_angle,
    input wire stage_cfg_s i_stage_one_cfg,
    input wire stage_cfg_s i_stage_two_cfg,
    input wire stage_cfg_s i_stage_three_cfg,
    input wire logic o_ground_direction_stage_one,
    input wire logic o_ground_direction_stage_two,
    input wire logic o_ground_direction_stage_three,
    input wire logic o_angle_in_area
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // boundaries at +/-90 degrees are outside the area
    function automatic logic in_area(int a, int m);
        int d;
        d = (a + 360 - m) % 360;
        return d < 90 || d > 270;
    endfunction
    use_one_a: assert property (
        !i_stage_one_cfg.use_enable |=> !o_ground_direction_stage_one)
        else $error("stage one trips while off");
    use_two_a: assert property (
        !i_stage_two_cfg.use_enable |=> !o_ground_direction_stage_two)
        else $error("stage two trips while off");
    area_calc_a: assert property ($past(i_rst_n) |->
        o_angle_in_area == in_area($past(i_meas.angle), $past(i_max_sensitivity_angle)))
        else $error("angle area flag wrong");
    rise_area_a: assert property (
        $rose(o_ground_direction_stage_one) |-> $past(o_angle_in_area, 2))
        else $error("trip without angle in area");
    cur_one_a: assert property (
        (i_meas.current <= i_stage_one_cfg.pickup_current)[*3]
        |-> !$rose(o_ground_direction_stage_one)) else $error("trip at low current");
    volt_three_a: assert property (
        (i_meas.voltage <= i_stage_three_cfg.pickup_voltage)[*3]
        |-> !$rose(o_ground_direction_stage_three)) else $error("trip at low voltage");
    restrain_two_a: assert property (
        (i_stage_two_cfg.harmonic_restraint_enable && i_meas.harmonic_detect)[*3]
        |-> !$rose(o_ground_direction_stage_two)) else $error("stage two not restrained");
    restrain_three_a: assert property (
        (i_stage_three_cfg.harmonic_restraint_enable && i_meas.harmonic_detect)[*3]
        |-> !$rose(o_ground_direction_stage_three)) else $error("stage three not restrained");
    hold_two_a: assert property (
        $rose(o_ground_direction_stage_two) ##0 i_stage_two_cfg.use_enable[*6]
        |-> o_ground_direction_stage_two) else $error("trip dropped before off-delay");
    cover property ($rose(o_ground_direction_stage_three));
    cover property ($fell(o_ground_direction_stage_one));
    cover property (i_meas.harmonic_detect && o_ground_direction_stage_two);
endmodule
bind directional_ground_fault_logic dirg_checker #(
    .STEP_CNT(STEP_CNT),
    .OFF_CNT(OFF_CNT)
) u_dirg_checker (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sample_tick(i_sample_tick),
    .i_meas(i_meas),
    .i_max_sensitivity_angle(i_max_sensitivity_angle),
    .i_stage_one_cfg(i_stage_one_cfg),
    .i_stage_two_cfg(i_stage_two_cfg),
    .i_stage_three_cfg(i_stage_three_cfg),
    .o_ground_direction_stage_one(o_ground_direction_stage_one),
    .o_ground_direction_stage_two(o_ground_direction_stage_two),
    .o_ground_direction_stage_three(o_ground_direction_stage_three),
    .o_angle_in_area(o_angle_in_area)
);

/* tb/meas_front_model.sv */
// measurement front end model: registers commanded sequence quantities
// assumes one clock; the sample tick runs free, as a sampler does
`timescale 1ns/1ps
module meas_front_model import dirg_pkg::*; #(parameter int TICK_DIV = 5) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire measure_s i_set,
    output measure_s o_meas = '0,
    output logic o_tick = 1'b0
);
    int cnt = 0;
    always @(posedge i_clk)
    begin
        cnt <= (!i_rst_n || cnt == TICK_DIV - 1) ? 0 : cnt + 1;
        o_tick <= i_rst_n && cnt == TICK_DIV - 1;
        o_meas <= i_set;
    end
endmodule

/* tb/testbench.sv */
// self-checking bench for the three ground fault stages
// assumes short counts: 4 cycles per delay step, 6 cycles off-delay
`timescale 1ns/1ps
module testbench import dirg_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    measure_s set = '0;
    logic [ANG_W-1:0] max_sensitivity_angle = '0;
    stage_cfg_s c1 = '0, c2 = '0, c3 = '0;
    measure_s meas;
    logic tick, o1, o2, o3, area;
    int bad_count = 0, n_checks = 0;
    logic [3:0] q[$];
    event chk;
    meas_front_model u_meas_front_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_set(set),
        .o_meas(meas), .o_tick(tick));
    directional_ground_fault_logic #(.STEP_CNT(4), .OFF_CNT(6)) u_directional_ground_fault_logic (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample_tick(tick), .i_meas(meas),
        .i_max_sensitivity_angle(max_sensitivity_angle), .i_stage_one_cfg(c1), .i_stage_two_cfg(c2),
        .i_stage_three_cfg(c3), .o_ground_direction_stage_one(o1),
        .o_ground_direction_stage_two(o2), .o_ground_direction_stage_three(o3),
        .o_angle_in_area(area));
    initial forever #20 i_clk = ~i_clk;
    task automatic compare_trips(input logic [2:0] e);
        n_checks++;
        if ({o3, o2, o1} !== e)
        begin
            bad_count++;
            $display("BAD trips expected %b seen %b", e, {o3, o2, o1});
        end
    endtask
    task automatic compare_area(input logic e);
        n_checks++;
        if (area !== e)
        begin
            bad_count++;
            $display("BAD area expected %b seen %b", e, area);
        end
    endtask
    always @(chk)
    begin
        logic [3:0] n;
        n = q.pop_front();
        compare_trips(n[2:0]);
        compare_area(n[3]);
    end
    task automatic note(input logic [3:0] e);
        q.push_back(e);
        @(negedge i_clk) -> chk;
    endtask
    // cvah: current over, voltage over, angle inside, harmonic seen
    task automatic run(input logic [3:0] cvah, input logic [2:0] en, rs, e);
        logic [CUR_W-1:0] pc;
        logic [VOLT_W-1:0] pv;
        logic [2:0] slow;
        int m, off;
        pc = 16'(1 + $urandom % 16'hfff0);
        pv = 10'(20 + $urandom % 880);
        slow = 3'($urandom);
        m = $urandom % 360;
        off = cvah[1] ? $urandom % 90 : 90 + $urandom % 181;
        @(posedge i_clk);
        max_sensitivity_angle <= 9'(m);
        c1 <= '{en[0], rs[0], pc, pv, slow[0] ? 10'h002 : 10'h000};
        c2 <= '{en[1], rs[1], pc, pv, slow[1] ? 10'h002 : 10'h000};
        c3 <= '{en[2], rs[2], pc, pv, slow[2] ? 10'h002 : 10'h000};
        set <= '{cvah[3] ? pc + 16'h1 : pc, cvah[2] ? pv + 10'h1 : pv, 9'((m + off) % 360), cvah[0]};
        // a two-step delay cannot have tripped by now, a zero delay must have
        repeat (11) @(posedge i_clk);
        note({cvah[1], e & ~slow});
        repeat (19) @(posedge i_clk);
        note({cvah[1], e});
        @(posedge i_clk);
        set.current <= '0;
        // last cycle of the off-delay, then the fall on the next edge
        repeat (8) @(posedge i_clk);
        note({cvah[1], e});
        @(posedge i_clk);
        note({cvah[1], 3'b000});
        $display("test %b done", cvah);
    endtask
    task automatic end_of_test;
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h6b04));
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            run(4'b1110, 3'b111, 3'b000, 3'b111);
            run(4'b0110, 3'b111, 3'b000, 3'b000);
            run(4'b1010, 3'b111, 3'b000, 3'b000);
            run(4'b1100, 3'b111, 3'b000, 3'b000);
            run(4'b1111, 3'b111, 3'b111, 3'b001);
            run(4'b1111, 3'b111, 3'b000, 3'b111);
            run(4'b1110, i ? 3'b101 : 3'b010, 3'b000, i ? 3'b101 : 3'b010);
        end
        @(posedge i_clk);
        end_of_test();
    end
endmodule
